/* File: src/hub_port_power_strap_ctrl.v */
// Downstream power, overcurrent, strap and shared pin control of a hub
//
// Contract
// - Low shared overcurrent input means overcurrent
// - Shared power enable low means power on
// - Small package: clock strap picks data/power
// - CC1 strap pull-up picks general hub mode
// - Power-delivery mode leaves port power alone
// - Serial pins: SMBus or companion link by mode
// - General mode, swap disabled: sleep indicator high when asleep
// - General mode, swap enabled: low CC2 input swaps ports
// - Low external reset input holds device reset
// - Per-port mode: four low-active power enables
// - Per-port mode: port 1 overcurrent input
// - Reference oscillator from external crystal
// - Gang strap high picks combined arrangement
`timescale 1ns/1ps
`include "hub_power_defines.vh"
module hub_port_power_strap_ctrl (
   // Clock and reset
   input wire clk_sys,
   input wire sys_rst,
   input wire ext_reset_in_n,
   // Crystal
   input wire crystal_in,
   output wire crystal_out,
   // Package variant tie
   input wire small_package,
   // Register port
   input wire [`ADDR_W-1:0] reg_addr,
   input wire [`DATA_W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [`DATA_W-1:0] reg_rdata,
   output wire irq,
   // Overcurrent and strap pins
   input wire shared_overcurrent_in_n,
   input wire port_overcurrent_in_n_1,
   input wire combined_mode_strap,
   // Shared power enable, small package pin
   output reg shared_port_power_on_n,
   output reg shared_power_oe_n,
   // Power enable / CC1 strap pin
   input wire cc1_pin_in,
   output reg cc1_pin_out,
   output reg cc1_pin_oe_n,
   // Per-port power enables
   output reg port_power_on_n_1,
   output reg port_power_on_n_2,
   output reg port_power_on_n_3,
   output reg port_power_on_n_4,
   // Sleep indicator / CC2 pin
   input wire cc2_pin_in,
   output reg cc2_pin_out,
   output reg cc2_pin_oe_n,
   // Management serial pins
   input wire mgmt_serial_data_in,
   output reg mgmt_serial_data_out,
   output reg mgmt_serial_data_oe_n,
   input wire mgmt_serial_clock_in,
   output reg mgmt_serial_clock_out,
   output reg mgmt_serial_clock_oe_n,
   // Hub core side
   input wire hub_sleep,
   input wire smb_data_drive_low,
   input wire link_data_out,
   input wire link_data_oe,
   input wire link_clock_out,
   output reg serial_data_level,
   output reg serial_clock_level,
   output wire power_delivery_hub_mode,
   output wire port_swap
);

   // ****************************************
   // Signals
   // ****************************************
   wire [`SYNC_W-1:0] pin_raw; // Pin levels, asynchronous
   wire [`SYNC_W-1:0] pin_s; // Pin levels after two flops
   wire func_rst; // Device held in reset
   reg combined_ff; // Combined arrangement latched
   reg general_ff; // General hub mode latched
   reg shared_smb_ff; // Shared pin is SMBus data
   reg strap_done_ff; // Straps frozen
   reg [`CTRL_SWAP_EN:0] ctrl_ff; // Control register
   reg [`INT_W-1:0] int_stat_ff; // Sticky events
   reg [`INT_W-1:0] int_mask_ff; // Event mask
   reg [`INT_W-1:0] nxt_int_stat; // Next sticky value
   reg [`INT_W-1:0] oc_prev_ff; // Overcurrent asserted last cycle
   wire [`INT_W-1:0] oc_now; // Overcurrent asserted now
   wire [`INT_W-1:0] oc_rise; // New overcurrent events
   wire [`CTRL_PWR_HI:`CTRL_PWR_LO] pwr_on; // Per-port power wanted
   wire swap_now; // Swap input asserted

   // ****************************************
   // Shared helpers
   // ****************************************
   // Address match for one register
   function hit;
      input [`ADDR_W-1:0] addr;
      input [`ADDR_W-1:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   // Active-low level to asserted flag
   function asserted_n;
      input level_n;
      begin
         asserted_n = ~level_n;
      end
   endfunction

   // ****************************************
   // Oscillator
   // ****************************************
   // inverting crystal amplifier
   // Only the amplifier stage; the core clock arrives on clk_sys
   assign crystal_out = ~crystal_in;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   assign pin_raw[`SY_RST_N] = ext_reset_in_n;
   assign pin_raw[`SY_SHARED_OC] = shared_overcurrent_in_n;
   assign pin_raw[`SY_PORT1_OC] = port_overcurrent_in_n_1;
   assign pin_raw[`SY_COMBINED] = combined_mode_strap;
   assign pin_raw[`SY_CC1] = cc1_pin_in;
   assign pin_raw[`SY_SCL] = mgmt_serial_clock_in;
   assign pin_raw[`SY_CC2] = cc2_pin_in;
   assign pin_raw[`SY_SDA] = mgmt_serial_data_in;

   // every strap and pin through two flops
   pin_sync #(
      .WIDTH(`SYNC_W)
   ) u_pin_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .async_in(pin_raw),
      .sync_out(pin_s)
   );

   // low reset input holds reset
   // Pull-up is external to this logic; a floating pin reads high
   assign func_rst = ~pin_s[`SY_RST_N];

   // ****************************************
   // Strap capture
   // ****************************************
   // Straps follow the pins while in reset and freeze at release
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         combined_ff <= 1'b1;
         general_ff <= 1'b1;
         shared_smb_ff <= 1'b0;
         strap_done_ff <= 1'b0;
      end else if (func_rst) begin
         combined_ff <= pin_s[`SY_COMBINED];
         general_ff <= pin_s[`SY_CC1];
         shared_smb_ff <= small_package & pin_s[`SY_SCL];
         strap_done_ff <= 1'b0;
      end else begin
         strap_done_ff <= 1'b1;
      end
   end

   assign power_delivery_hub_mode = ~general_ff;

   // ****************************************
   // Overcurrent events
   // ****************************************
   // shared input low is overcurrent
   assign oc_now[`INT_SHARED_OC] = combined_ff & asserted_n(pin_s[`SY_SHARED_OC]);
   // port 1 input low is overcurrent
   assign oc_now[`INT_PORT1_OC] = ~combined_ff & asserted_n(pin_s[`SY_PORT1_OC]);
   assign oc_rise = oc_now & ~oc_prev_ff;

   // Edge memory; cleared in reset, so a fault held through release is reported
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         oc_prev_ff <= `INT_RST;
      end else if (func_rst) begin
         oc_prev_ff <= `INT_RST;
      end else begin
         oc_prev_ff <= oc_now;
      end
   end

   // Sticky status; a new event wins over a same-cycle clear
   always @* begin
      nxt_int_stat = int_stat_ff;
      if (reg_wr && hit(reg_addr, `OFF_INT_STAT)) begin
         nxt_int_stat = nxt_int_stat & ~reg_wdata[`INT_W-1:0];
      end
      nxt_int_stat = nxt_int_stat | oc_rise;
   end

   // ****************************************
   // Register writes
   // ****************************************
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_ff <= `CTRL_RST;
         int_stat_ff <= `INT_RST;
         int_mask_ff <= `INT_RST;
      end else if (func_rst) begin
         // Device reset clears software state too
         ctrl_ff <= `CTRL_RST;
         int_stat_ff <= `INT_RST;
         int_mask_ff <= `INT_RST;
      end else begin
         int_stat_ff <= nxt_int_stat;
         if (reg_wr && hit(reg_addr, `OFF_CTRL)) begin
            ctrl_ff <= reg_wdata[`CTRL_SWAP_EN:0];
         end
         if (reg_wr && hit(reg_addr, `OFF_INT_MASK)) begin
            int_mask_ff <= reg_wdata[`INT_W-1:0];
         end
      end
   end

   // Level interrupt while any unmasked event is pending
   assign irq = |(int_stat_ff & int_mask_ff);

   // ****************************************
   // Register reads
   // ****************************************
   // Data stands in the cycle after the read strobe only
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= {`DATA_W{1'b0}};
      end else begin
         reg_rdata <= {`DATA_W{1'b0}};
         if (reg_rd) begin
            case (reg_addr)
               `OFF_CTRL: begin
                  reg_rdata[`CTRL_SWAP_EN:0] <= ctrl_ff;
               end
               `OFF_STATUS: begin
                  reg_rdata[`ST_COMBINED] <= combined_ff;
                  reg_rdata[`ST_GENERAL] <= general_ff;
                  reg_rdata[`ST_SHARED_SMB] <= shared_smb_ff;
                  reg_rdata[`ST_SHARED_OC] <= oc_now[`INT_SHARED_OC];
                  reg_rdata[`ST_PORT1_OC] <= oc_now[`INT_PORT1_OC];
                  reg_rdata[`ST_SWAPPED] <= swap_now;
                  reg_rdata[`ST_PWR_HI:`ST_PWR_LO] <= pwr_on;
                  reg_rdata[`ST_DONE] <= strap_done_ff;
               end
               `OFF_INT_STAT: begin
                  reg_rdata[`INT_W-1:0] <= int_stat_ff;
               end
               `OFF_INT_MASK: begin
                  reg_rdata[`INT_W-1:0] <= int_mask_ff;
               end
               default: begin
                  // Unmapped address reads zero
                  reg_rdata <= {`DATA_W{1'b0}};
               end
            endcase
         end
      end
   end

   // ****************************************
   // Power decisions
   // ****************************************
   // Overcurrent drops power at once, ahead of software
   // nothing switched in power-delivery mode
   assign pwr_on[0] = general_ff & ctrl_ff[`CTRL_PWR_LO]
                      & ~oc_now[`INT_PORT1_OC] & ~oc_now[`INT_SHARED_OC];
   assign pwr_on[3:1] = {3{general_ff & ~oc_now[`INT_SHARED_OC]}}
                        & ctrl_ff[`CTRL_PWR_HI:`CTRL_PWR_LO+1];

   // swap only when enabled and input low
   assign swap_now = general_ff & ctrl_ff[`CTRL_SWAP_EN] & ~pin_s[`SY_CC2];
   assign port_swap = swap_now;

   // ****************************************
   // Power pins
   // ****************************************
   // All pins released or off while in reset so straps read cleanly
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         shared_port_power_on_n <= 1'b1;
         shared_power_oe_n <= 1'b1;
         cc1_pin_out <= 1'b1;
         cc1_pin_oe_n <= 1'b1;
         port_power_on_n_1 <= 1'b1;
         port_power_on_n_2 <= 1'b1;
         port_power_on_n_3 <= 1'b1;
         port_power_on_n_4 <= 1'b1;
      end else if (func_rst) begin
         shared_port_power_on_n <= 1'b1;
         shared_power_oe_n <= 1'b1;
         cc1_pin_out <= 1'b1;
         cc1_pin_oe_n <= 1'b1;
         port_power_on_n_1 <= 1'b1;
         port_power_on_n_2 <= 1'b1;
         port_power_on_n_3 <= 1'b1;
         port_power_on_n_4 <= 1'b1;
      end else begin
         shared_port_power_on_n <= ~(combined_ff & (|pwr_on));
         // pin released when it serves SMBus data
         shared_power_oe_n <= ~(small_package & ~shared_smb_ff);
         cc1_pin_out <= ~(combined_ff & (|pwr_on));
         // CC1 pin not driven in power-delivery mode
         cc1_pin_oe_n <= ~(general_ff & ~small_package);
         port_power_on_n_1 <= ~(~combined_ff & pwr_on[0]);
         port_power_on_n_2 <= ~(~combined_ff & pwr_on[1]);
         port_power_on_n_3 <= ~(~combined_ff & pwr_on[2]);
         port_power_on_n_4 <= ~(~combined_ff & pwr_on[3]);
      end
   end

   // ****************************************
   // Sleep indicator and serial pins
   // ****************************************
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cc2_pin_out <= 1'b0;
         cc2_pin_oe_n <= 1'b1;
         mgmt_serial_data_out <= 1'b1;
         mgmt_serial_data_oe_n <= 1'b1;
         mgmt_serial_clock_out <= 1'b1;
         mgmt_serial_clock_oe_n <= 1'b1;
         serial_data_level <= 1'b1;
         serial_clock_level <= 1'b1;
      end else if (func_rst) begin
         cc2_pin_out <= 1'b0;
         cc2_pin_oe_n <= 1'b1;
         mgmt_serial_data_out <= 1'b1;
         mgmt_serial_data_oe_n <= 1'b1;
         mgmt_serial_clock_out <= 1'b1;
         mgmt_serial_clock_oe_n <= 1'b1;
         serial_data_level <= 1'b1;
         serial_clock_level <= 1'b1;
      end else begin
         // high asleep, low in normal running
         cc2_pin_out <= hub_sleep;
         // Driven only in general mode with swap disabled
         cc2_pin_oe_n <= ~(general_ff & ~ctrl_ff[`CTRL_SWAP_EN]);
         serial_data_level <= pin_s[`SY_SDA];
         serial_clock_level <= pin_s[`SY_SCL];
         // SMBus in general, companion link otherwise
         if (general_ff) begin
            // Open drain data, clock is an input
            mgmt_serial_data_out <= 1'b0;
            mgmt_serial_data_oe_n <= ~smb_data_drive_low;
            mgmt_serial_clock_out <= 1'b1;
            mgmt_serial_clock_oe_n <= 1'b1;
         end else begin
            mgmt_serial_data_out <= link_data_out;
            mgmt_serial_data_oe_n <= ~link_data_oe;
            mgmt_serial_clock_out <= link_clock_out;
            mgmt_serial_clock_oe_n <= 1'b0;
         end
      end
   end

endmodule

/* File: src/hub_power_defines.vh */
// Constants for the hub port power and strap control block
`ifndef HUB_POWER_DEFINES_VH
`define HUB_POWER_DEFINES_VH

// ****************************************
// Register bus
// ****************************************
`define ADDR_W 8
`define DATA_W 32
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_INT_STAT 8'h08
`define OFF_INT_MASK 8'h0C

// ****************************************
// Control register fields
// ****************************************
`define CTRL_PWR_LO 0
`define CTRL_PWR_HI 3
`define CTRL_SWAP_EN 4
`define CTRL_RST 5'h00

// ****************************************
// Status register fields
// ****************************************
`define ST_COMBINED 0
`define ST_GENERAL 1
`define ST_SHARED_SMB 2
`define ST_SHARED_OC 3
`define ST_PORT1_OC 4
`define ST_SWAPPED 5
`define ST_PWR_LO 6
`define ST_PWR_HI 9
`define ST_DONE 10

// ****************************************
// Interrupt bits
// ****************************************
`define INT_W 2
`define INT_SHARED_OC 0
`define INT_PORT1_OC 1
`define INT_RST 2'h0

// ****************************************
// Synchroniser lanes
// ****************************************
`define SYNC_W 8
`define SY_RST_N 0
`define SY_SHARED_OC 1
`define SY_PORT1_OC 2
`define SY_COMBINED 3
`define SY_CC1 4
`define SY_SCL 5
`define SY_CC2 6
`define SY_SDA 7

`endif

/* File: src/pin_sync.v */
// Two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // Levels
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_ff; // First stage, read only by second
   reg [WIDTH-1:0] sync_ff; // Second stage, safe to use

   // ****************************************
   // Two flip-flops per lane
   // ****************************************
   // Resets to zero; the active-low reset lane thus starts in reset
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         meta_ff <= {WIDTH{1'b0}};
         sync_ff <= {WIDTH{1'b0}};
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule

/* File: bench/hub_port_power_strap_ctrl_props.sv */
// Assertion checker for the hub port power and strap control block
`timescale 1ns/1ps
module hub_port_power_strap_ctrl_props (
   // Clock and reset
   input wire clk_sys,
   input wire sys_rst,
   input wire ext_reset_in_n,
   // Crystal and register port
   input wire crystal_in,
   input wire crystal_out,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   // Pins and hub side
   input wire shared_overcurrent_in_n,
   input wire port_overcurrent_in_n_1,
   input wire shared_port_power_on_n,
   input wire cc1_pin_oe_n,
   input wire port_power_on_n_1,
   input wire port_power_on_n_2,
   input wire port_power_on_n_3,
   input wire port_power_on_n_4,
   input wire cc2_pin_in,
   input wire cc2_pin_out,
   input wire cc2_pin_oe_n,
   input wire hub_sleep,
   input wire power_delivery_hub_mode,
   input wire port_swap
);
   // ****************************************
   // Shared clocking
   // ****************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   // Pin held long enough to pass the synchroniser and output stage
   sequence shared_oc_held;
      !shared_overcurrent_in_n [*3];
   endsequence
   sequence port1_oc_held;
      !port_overcurrent_in_n_1 [*3];
   endsequence
   // Extra cycle over the pin path is margin; the internal reset flag is not registered and adds no delay
   sequence ext_rst_held;
      !ext_reset_in_n [*5];
   endsequence
   // ****************************************
   // Properties
   // ****************************************
   chk_reset_power_off: assert property (ext_rst_held |-> port_power_on_n_1 &&
      port_power_on_n_2 && port_power_on_n_3 && port_power_on_n_4 && shared_port_power_on_n)
      else $error("power enable low during device reset");
   chk_shared_oc_off: assert property (shared_oc_held |=> shared_port_power_on_n)
      else $error("shared power on during overcurrent");
   chk_port1_oc_off: assert property (port1_oc_held |=> port_power_on_n_1)
      else $error("port one power on during overcurrent");
   chk_pd_no_power: assert property (power_delivery_hub_mode |-> cc1_pin_oe_n &&
      port_power_on_n_1 && port_power_on_n_2 && port_power_on_n_3 && port_power_on_n_4)
      else $error("power driven in power delivery mode");
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside read answer cycle");
   chk_crystal_inv: assert property (crystal_out == !crystal_in)
      else $error("crystal output not inverted");
   chk_swap_needs_low: assert property (port_swap |-> !$past(cc2_pin_in, 2))
      else $error("swap without low control input");
   chk_sleep_drive: assert property ($rose(hub_sleep) && !cc2_pin_oe_n |-> ##[1:3] cc2_pin_out)
      else $error("sleep indicator not raised");
endmodule
bind hub_port_power_strap_ctrl hub_port_power_strap_ctrl_props u_hub_port_power_strap_ctrl_props (.*);

/* File: bench/hub_pin_partner.sv */
// Behavioural model of power switches and strap resistors around the hub
`timescale 1ns/1ps
module hub_pin_partner (
   // Board set-up
   input wire gang_pull_up,
   input wire cc1_pull_up,
   input wire scl_pull_up,
   input wire cc2_drive_low,
   input wire shared_fault,
   input wire port1_fault,
   // Device drives
   input wire cc1_pin_out,
   input wire cc1_pin_oe_n,
   input wire cc2_pin_out,
   input wire cc2_pin_oe_n,
   input wire mgmt_serial_data_out,
   input wire mgmt_serial_data_oe_n,
   input wire mgmt_serial_clock_out,
   input wire mgmt_serial_clock_oe_n,
   // Levels seen by the device
   output wire combined_mode_strap,
   output wire shared_overcurrent_in_n,
   output wire port_overcurrent_in_n_1,
   output wire cc1_pin_in,
   output wire cc2_pin_in,
   output wire mgmt_serial_data_in,
   output wire mgmt_serial_clock_in
);
   assign combined_mode_strap = gang_pull_up;
   assign shared_overcurrent_in_n = !shared_fault;
   assign port_overcurrent_in_n_1 = !port1_fault;
   assign cc1_pin_in = !cc1_pin_oe_n ? cc1_pin_out : cc1_pull_up;
   assign cc2_pin_in = !cc2_pin_oe_n ? cc2_pin_out : !cc2_drive_low;
   // data line has a bus pull-up
   assign mgmt_serial_data_in = mgmt_serial_data_oe_n | mgmt_serial_data_out;
   assign mgmt_serial_clock_in = !mgmt_serial_clock_oe_n ? mgmt_serial_clock_out : scl_pull_up;
endmodule

/* File: bench/hub_port_power_strap_ctrl_tb_top.sv */
// Self-checking bench for the hub port power and strap control block
`timescale 1ns/1ps
`include "hub_power_defines.vh"
module hub_port_power_strap_ctrl_tb_top;
   // Stimulus and board set-up
   reg clk_sys = 0, sys_rst = 1, ext_reset_in_n = 0, crystal_in = 0, small_package = 0;
   reg [7:0] reg_addr = 0;
   reg [31:0] reg_wdata = 0;
   reg reg_wr = 0, reg_rd = 0, hub_sleep = 0, smb_data_drive_low = 0;
   reg link_data_out = 0, link_data_oe = 0, link_clock_out = 0;
   reg gang_pull_up = 1, cc1_pull_up = 1, scl_pull_up = 0, cc2_drive_low = 0;
   reg shared_fault = 0, port1_fault = 0;
   integer err_count = 0, total_checks = 0;
   // Device outputs and pin levels
   wire [31:0] reg_rdata;
   wire irq, crystal_out, shared_port_power_on_n, shared_power_oe_n, cc1_pin_out, cc1_pin_oe_n;
   wire port_power_on_n_1, port_power_on_n_2, port_power_on_n_3, port_power_on_n_4;
   wire cc2_pin_out, cc2_pin_oe_n, mgmt_serial_data_out, mgmt_serial_data_oe_n;
   wire mgmt_serial_clock_out, mgmt_serial_clock_oe_n, serial_data_level, serial_clock_level;
   wire power_delivery_hub_mode, port_swap, combined_mode_strap, shared_overcurrent_in_n;
   wire port_overcurrent_in_n_1, cc1_pin_in, cc2_pin_in, mgmt_serial_data_in, mgmt_serial_clock_in;
   wire [31:0] ports_n = {28'h0, port_power_on_n_4, port_power_on_n_3, port_power_on_n_2,
      port_power_on_n_1};
   hub_port_power_strap_ctrl u_hub_port_power_strap_ctrl (.*);
   hub_pin_partner u_hub_pin_partner (.*);
   // Clock and a free running crystal level
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      crystal_in <= ~crystal_in;
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task cmp_bit(input [95:0] nm, input e, input g);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("Error %0s expected %b seen %b", nm, e, g);
         end
      end
   endtask
   task cmp_word(input [95:0] nm, input [31:0] e, input [31:0] g);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("Error %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task gap(input integer n);
      begin
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'h1;
         @(posedge clk_sys);
         reg_wr <= 1'h0;
      end
   endtask
   // Read data stand only in the cycle after the strobe
   task rd_cmp(input [7:0] a, input [31:0] m, input [31:0] e, input [95:0] nm);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_rd <= 1'h1;
         @(posedge clk_sys);
         reg_rd <= 1'h0;
         #1;
         cmp_word(nm, e, reg_rdata & m);
      end
   endtask
   // Straps are fitted in the same cycle that reset is applied and held through it
   task board(input g, input c, input s, input p);
      begin
         @(posedge clk_sys);
         {gang_pull_up, cc1_pull_up, scl_pull_up, small_package} <= {g, c, s, p};
         sys_rst <= 1'h1;
         ext_reset_in_n <= 1'h0;
         gap(12);
         @(posedge clk_sys);
         sys_rst <= 1'h0;
         gap(2);
         @(posedge clk_sys);
         ext_reset_in_n <= 1'h1;
         gap(8);
      end
   endtask
   task test_done;
      begin
         $display("Checks %0d errors %0d", total_checks, err_count);
         if (err_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
         end else begin
            $display("SIMULATION FAILED");
         end
         $finish;
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task t_combined;
      begin
         board(1'h1, 1'h1, 1'h0, 1'h0);
         rd_cmp(`OFF_STATUS, 32'h0000_0407, 32'h0000_0403, "status");
         cmp_bit("pd_mode", 1'h0, power_delivery_hub_mode);
         wr(`OFF_CTRL, 32'h0000_0001);
         gap(3);
         cmp_bit("cc1_out", 1'h0, cc1_pin_out);
         cmp_bit("cc1_oe_n", 1'h0, cc1_pin_oe_n);
         cmp_word("ports", 32'h0000_000F, ports_n);
         cmp_bit("scl_oe_n", 1'h1, mgmt_serial_clock_oe_n);
         cmp_bit("xtal", ~crystal_in, crystal_out);
         // SMBus data pulled low by the core, clock left to its resistor
         @(posedge clk_sys);
         smb_data_drive_low <= 1'h1;
         gap(5);
         cmp_bit("sda_oe_n", 1'h0, mgmt_serial_data_oe_n);
         cmp_bit("sda_lvl", 1'h0, serial_data_level);
         cmp_bit("scl_lvl", 1'h0, serial_clock_level);
         @(posedge clk_sys);
         smb_data_drive_low <= 1'h0;
         rd_cmp(8'h10, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
         // Masked event must stay silent until unmasked
         @(posedge clk_sys);
         shared_fault <= 1'h1;
         gap(4);
         cmp_bit("cc1_oc", 1'h1, cc1_pin_out);
         cmp_bit("irq_mask", 1'h0, irq);
         wr(`OFF_INT_MASK, 32'h0000_0001);
         gap(2);
         cmp_bit("irq_on", 1'h1, irq);
         @(posedge clk_sys);
         shared_fault <= 1'h0;
         gap(4);
         rd_cmp(`OFF_INT_STAT, 32'h0000_0003, 32'h0000_0001, "int_stat");
         wr(`OFF_INT_STAT, 32'h0000_0001);
         gap(2);
         cmp_bit("irq_clr", 1'h0, irq);
         cmp_bit("cc1_back", 1'h0, cc1_pin_out);
      end
   endtask
   task t_sleep_swap;
      begin
         @(posedge clk_sys);
         hub_sleep <= 1'h1;
         gap(4);
         cmp_bit("sleep_hi", 1'h1, cc2_pin_out);
         cmp_bit("cc2_oe_n", 1'h0, cc2_pin_oe_n);
         @(posedge clk_sys);
         hub_sleep <= 1'h0;
         gap(4);
         cmp_bit("sleep_lo", 1'h0, cc2_pin_out);
         wr(`OFF_CTRL, 32'h0000_0011);
         @(posedge clk_sys);
         cc2_drive_low <= 1'h1;
         gap(5);
         cmp_bit("swap_on", 1'h1, port_swap);
         cmp_bit("cc2_rel", 1'h1, cc2_pin_oe_n);
         @(posedge clk_sys);
         cc2_drive_low <= 1'h0;
         gap(5);
         cmp_bit("swap_off", 1'h0, port_swap);
      end
   endtask
   task t_per_port;
      begin
         board(1'h0, 1'h1, 1'h0, 1'h0);
         wr(`OFF_CTRL, 32'h0000_000F);
         gap(3);
         cmp_word("ports_on", 32'h0000_0000, ports_n);
         @(posedge clk_sys);
         port1_fault <= 1'h1;
         gap(4);
         cmp_word("port1_oc", 32'h0000_0001, ports_n);
         rd_cmp(`OFF_INT_STAT, 32'h0000_0003, 32'h0000_0002, "int_p1");
         @(posedge clk_sys);
         port1_fault <= 1'h0;
      end
   endtask
   task t_pd;
      begin
         board(1'h1, 1'h0, 1'h0, 1'h0);
         cmp_bit("pd_mode", 1'h1, power_delivery_hub_mode);
         wr(`OFF_CTRL, 32'h0000_000F);
         @(posedge clk_sys);
         {link_data_out, link_data_oe, link_clock_out} <= 3'h7;
         gap(3);
         cmp_word("pd_ports", 32'h0000_000F, ports_n);
         cmp_bit("pd_cc1", 1'h1, cc1_pin_oe_n);
         cmp_bit("link_oe", 1'h0, mgmt_serial_data_oe_n);
         cmp_bit("link_dat", 1'h1, mgmt_serial_data_out);
         cmp_bit("link_clk", 1'h1, mgmt_serial_clock_out);
      end
   endtask
   task t_small_reset;
      begin
         board(1'h1, 1'h1, 1'h1, 1'h1);
         rd_cmp(`OFF_STATUS, 32'h0000_0004, 32'h0000_0004, "smb_pin");
         board(1'h1, 1'h1, 1'h0, 1'h1);
         rd_cmp(`OFF_STATUS, 32'h0000_0004, 32'h0000_0000, "pwr_pin");
         wr(`OFF_CTRL, 32'h0000_0001);
         gap(3);
         cmp_bit("sh_oe_n", 1'h0, shared_power_oe_n);
         cmp_bit("sh_pwr", 1'h0, shared_port_power_on_n);
         // Strap moved in reset is latched; moved back after release it must not change the mode
         @(posedge clk_sys);
         gang_pull_up <= 1'h0;
         ext_reset_in_n <= 1'h0;
         gap(5);
         cmp_bit("rst_pwr", 1'h1, shared_port_power_on_n);
         @(posedge clk_sys);
         ext_reset_in_n <= 1'h1;
         gap(4);
         @(posedge clk_sys);
         gang_pull_up <= 1'h1;
         gap(4);
         rd_cmp(`OFF_STATUS, 32'h0000_0401, 32'h0000_0400, "latched");
         rd_cmp(`OFF_CTRL, 32'h0000_001F, 32'h0000_0000, "ctrl_clr");
      end
   endtask
   // ****************************************
   // Main sequence and hang guard
   // ****************************************
   initial begin
      t_combined;
      t_sleep_swap;
      t_per_port;
      t_pd;
      t_small_reset;
      test_done;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count = err_count + 1;
      $display("Error watchdog expected finish seen hang");
      test_done;
   end
endmodule
